// file: logic/dsc_top.sv
// serial command decoder and per-channel register bank
`timescale 1ns/100ps
`default_nettype none
// Operation
// - every output powers up high impedance before programming
// - data shifts in on serial clock rising edges while select is low
// - word is command, channel, then 16-bit data, msb first
// - channel field values 0 to 4 pick channels 0 to 4
// - other channel values discard the whole command
// - 12-bit variant uses top 12 data bits, last four ignored
// - select rising edge executes the last 24 bits shifted in
// - 32-bit words carry 8 leading ignored bits
// - fault flags appear on serial output for either word length
// - codes are unsigned straight binary in every range
// - 0000 writes addressed code, 1000 writes all codes
// - input writes never touch active registers or outputs
// - two code holding registers per channel, A default, B toggle
// - 0001 updates addressed, 1001 all; update powers channel up
// - 0011 write and update n, 0010 update all, 1010 all
// - each update copies both code and range holding registers
// - updates come from commands, update pin, or toggle
// - each channel has double-buffered 4-bit range
// - 0110 writes addressed range, 1110 writes all ranges
// - updates move range holding into range active
// - range 0000 high impedance, 1000 shunt, undefined high impedance
// - clear input low zeroes codes, ranges and control state
// - update pin falling edge updates all only while select high
// - serial output is 32-bit delayed, falling-edge, off when idle
module dsc_top
    import dsc_pkg::*;
#(
    parameter int unsigned NUM_CH    = NUM_CH_DEF,
    parameter int unsigned CODE_BITS = CODE_BITS_DEF
) (
    input  wire logic                        CLK_SYS,
    input  wire logic                        NRST,
    input  wire logic                        SCK,
    input  wire logic                        SDI,
    input  wire logic                        SELECT_AND_LOAD_N,
    input  wire logic                        ASYNC_UPDATE_N,
    input  wire logic                        ASYNC_CLEAR_N,
    input  wire logic                        TOGGLE_INPUT_PIN,
    input  wire logic [NUM_CH-1:0]           TOGGLE_SEL,
    input  wire logic                        WRITE_TO_B,
    input  wire logic [FAULT_BITS-1:0]       FAULT_FLAG_BITS,
    output var  logic                        SDO,
    output logic                             SDO_OE,
    output logic [NUM_CH*CODE_BITS-1:0]      CODE_OUT,
    output logic [NUM_CH*4-1:0]              RANGE_OUT,
    output logic [NUM_CH-1:0]                OUT_HIZ,
    output logic [NUM_CH-1:0]                OUT_SHUNT,
    output logic [NUM_CH-1:0]                POWERED_DOWN,
    output var  logic                        AUX_CMD_VALID,
    output var  dsc_word_t                   AUX_CMD
);
    // parameter limits
    if (NUM_CH < 1 || NUM_CH > 16) begin : g_bad_ch
        $error("NUM_CH must be 1 to 16");
    end
    if (CODE_BITS != 12 && CODE_BITS != 16) begin : g_bad_code
        $error("CODE_BITS must be 12 or 16");
    end

    logic [5:0]             pins_s;
    logic                   sck_s;
    logic                   sdi_s;
    logic                   cs_s;
    logic                   async_update_n_s;
    logic                   clr_n_s;
    logic                   tgp_s;
    logic                   sck_d;
    logic                   cs_d;
    logic                   async_update_n_d;
    logic                   tgp_d;
    logic [FRAME_BITS-1:0]  shift_reg;
    logic [CNT_BITS-1:0]    bit_cnt;
    logic [FRAME_BITS-1:0]  next_shift_reg;
    logic [CNT_BITS-1:0]    next_bit_cnt;
    logic                   next_sdo;
    logic                   next_aux_valid;
    dsc_word_t              next_aux_cmd;
    logic                   sck_rise;
    logic                   sck_fall;
    logic                   cs_rise;
    logic                   cs_fall;
    logic                   async_update_n_fall;
    logic                   tgp_rise;
    logic                   tgp_fall;
    logic                   exec;
    logic [3:0]             cmd;
    logic [3:0]             addr;
    logic [CODE_BITS-1:0]   code_word;
    logic [3:0]             range_word;
    logic                   addr_ok;
    logic                   clr;
    dsc_ch_cmd_t            ch_cmd [NUM_CH];

    // the six serial and control pins cross two flops; idle levels at reset
    dsc_sync #(
        .WIDTH   (6),
        .RST_VAL (6'h1c)
    ) u_sync (
        .clk  (CLK_SYS),
        .nrst (NRST),
        .d    ({TOGGLE_INPUT_PIN, ASYNC_CLEAR_N, ASYNC_UPDATE_N,
                SELECT_AND_LOAD_N, SCK, SDI}),
        .q    (pins_s)
    );

    assign sdi_s   = pins_s[0];
    assign sck_s   = pins_s[1];
    assign cs_s    = pins_s[2];
    assign async_update_n_s  = pins_s[3];
    assign clr_n_s = pins_s[4];
    assign tgp_s   = pins_s[5];
    assign clr     = !clr_n_s;

    // edge detection on synchronised pins
    always_comb begin
        sck_rise  = sck_s && !sck_d && !cs_s;
        sck_fall  = !sck_s && sck_d && !cs_s;
        cs_fall   = !cs_s && cs_d;
        cs_rise   = cs_s && !cs_d;
        async_update_n_fall = !async_update_n_s && async_update_n_d && cs_s;
        tgp_rise  = tgp_s && !tgp_d;
        tgp_fall  = !tgp_s && tgp_d;
    end

    // fields of the last 24 bits shifted in
    always_comb begin
        cmd        = shift_reg[CMD_MSB:CMD_LSB];
        addr       = shift_reg[ADDR_MSB:ADDR_LSB];
        code_word  = shift_reg[DATA_MSB -: CODE_BITS];
        range_word = shift_reg[3:0];
        addr_ok    = 32'(addr) < NUM_CH;
        exec       = cs_rise && bit_cnt >= CNT_WORD && !clr;
    end

    // shift register, bit count and serial output
    always_comb begin
        next_shift_reg = shift_reg;
        next_bit_cnt   = bit_cnt;
        next_sdo       = SDO;
        if (cs_fall) begin
            // fault flags ahead of the previous word
            next_shift_reg[FRAME_BITS-1 -: FAULT_BITS] = FAULT_FLAG_BITS;
            next_bit_cnt = '0;
            next_sdo     = FAULT_FLAG_BITS[FAULT_BITS-1];
        end else if (sck_rise) begin
            next_shift_reg = {shift_reg[FRAME_BITS-2:0], sdi_s};
            if (bit_cnt != CNT_FULL) begin
                next_bit_cnt = bit_cnt + 6'h01;
            end
        end else if (sck_fall) begin
            next_sdo = shift_reg[FRAME_BITS-1];
        end
    end

    // per-channel command decode
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            logic sel_n;
            logic all;
            logic tog;
            sel_n = exec && addr_ok && addr == 4'(i);
            all   = exec && addr_ok;
            tog   = TOGGLE_SEL[i] && (tgp_rise || tgp_fall);
            ch_cmd[i].wr_code = (sel_n && (cmd == CMD_WR_CODE_N ||
                                 cmd == CMD_WR_N_UPD_N ||
                                 cmd == CMD_WR_N_UPD_ALL)) ||
                                (all && (cmd == CMD_WR_CODE_ALL ||
                                 cmd == CMD_WR_ALL_UPD));
            ch_cmd[i].wr_to_b  = WRITE_TO_B;
            ch_cmd[i].wr_range = (sel_n && cmd == CMD_WR_RANGE_N) ||
                                 (all && cmd == CMD_WR_RANGE_ALL);
            ch_cmd[i].update   = (sel_n && (cmd == CMD_UPD_N ||
                                 cmd == CMD_WR_N_UPD_N)) ||
                                 (all && (cmd == CMD_UPD_ALL ||
                                 cmd == CMD_WR_N_UPD_ALL ||
                                 cmd == CMD_WR_ALL_UPD)) ||
                                 (async_update_n_fall && !clr) || tog;
            ch_cmd[i].upd_from_b = tog && tgp_rise;
            ch_cmd[i].power_down = (sel_n && cmd == CMD_PD_N) ||
                                   (all && cmd == CMD_PD_CHIP);
        end
    end

    // commands whose payload is handled elsewhere
    always_comb begin
        next_aux_valid = exec && addr_ok &&
                         (cmd == CMD_MON_SEL || cmd == CMD_TOG_SEL ||
                          cmd == CMD_GLOBAL_TOG ||
                          cmd == CMD_CONFIG);
        next_aux_cmd   = AUX_CMD;
        if (next_aux_valid) begin
            next_aux_cmd = shift_reg[WORD_BITS-1:0];
        end
        if (clr) begin
            next_aux_cmd = '0;
        end
    end

    // link state registers
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            sck_d         <= 1'b0;
            cs_d          <= 1'b1;
            async_update_n_d        <= 1'b1;
            tgp_d         <= 1'b0;
            shift_reg     <= '0;
            bit_cnt       <= '0;
            SDO           <= SDO_RST;
            AUX_CMD_VALID <= 1'b0;
            AUX_CMD       <= '0;
        end else begin
            sck_d         <= sck_s;
            cs_d          <= cs_s;
            async_update_n_d        <= async_update_n_s;
            tgp_d         <= tgp_s;
            shift_reg     <= next_shift_reg;
            bit_cnt       <= next_bit_cnt;
            SDO           <= next_sdo;
            AUX_CMD_VALID <= next_aux_valid;
            AUX_CMD       <= next_aux_cmd;
        end
    end

    // serial output driven only while selected
    assign SDO_OE = !cs_s;

    // channel register sets
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        dsc_channel #(
            .CODE_BITS (CODE_BITS)
        ) u_ch (
            .clk          (CLK_SYS),
            .nrst         (NRST),
            .clr          (clr),
            .cmd          (ch_cmd[g]),
            .code_in      (code_word),
            .range_in     (range_word),
            .code_act     (CODE_OUT[g*CODE_BITS +: CODE_BITS]),
            .range_act    (RANGE_OUT[g*4 +: 4]),
            .powered_down (POWERED_DOWN[g]),
            .out_hiz      (OUT_HIZ[g]),
            .out_shunt    (OUT_SHUNT[g])
        );
    end
endmodule
`default_nettype wire

// file: logic/dsc_pkg.sv
// shared constants and types of the serial command register bank
`default_nettype none
package dsc_pkg;
    // word layout, counted from the last bit shifted in
    localparam int unsigned WORD_BITS  = 24;
    localparam int unsigned FRAME_BITS = 32;
    localparam int unsigned CMD_MSB    = 23;
    localparam int unsigned CMD_LSB    = 20;
    localparam int unsigned ADDR_MSB   = 19;
    localparam int unsigned ADDR_LSB   = 16;
    localparam int unsigned DATA_MSB   = 15;
    localparam int unsigned DATA_BITS  = 16;
    localparam int unsigned FAULT_BITS = 8;
    localparam int unsigned CNT_BITS   = 6;
    localparam logic [5:0]  CNT_FULL   = 6'h20;
    localparam logic [5:0]  CNT_WORD   = 6'h18;

    // defaults of the top-level parameters
    localparam int unsigned NUM_CH_DEF    = 5;
    localparam int unsigned CODE_BITS_DEF = 16;

    // range codes
    localparam logic [3:0] RANGE_HIZ     = 4'h0;
    localparam logic [3:0] RANGE_LOW_MAX = 4'h7;
    localparam logic [3:0] RANGE_SHUNT   = 4'h8;
    localparam logic [3:0] RANGE_TOP     = 4'hf;

    // reset values
    localparam logic [3:0] RANGE_RST = 4'h0;
    localparam logic       SDO_RST   = 1'b0;

    // command field encodings
    typedef enum logic [3:0] {
        CMD_WR_CODE_N     = 4'b0000,
        CMD_UPD_N         = 4'b0001,
        CMD_WR_N_UPD_ALL  = 4'b0010,
        CMD_WR_N_UPD_N    = 4'b0011,
        CMD_PD_N          = 4'b0100,
        CMD_PD_CHIP       = 4'b0101,
        CMD_WR_RANGE_N    = 4'b0110,
        CMD_CONFIG        = 4'b0111,
        CMD_WR_CODE_ALL   = 4'b1000,
        CMD_UPD_ALL       = 4'b1001,
        CMD_WR_ALL_UPD    = 4'b1010,
        CMD_MON_SEL       = 4'b1011,
        CMD_TOG_SEL       = 4'b1100,
        CMD_GLOBAL_TOG    = 4'b1101,
        CMD_WR_RANGE_ALL  = 4'b1110,
        CMD_NOP           = 4'b1111
    } dsc_cmd_t;

    // one cycle of actions for a single channel
    typedef struct packed {
        logic wr_code;
        logic wr_to_b;
        logic wr_range;
        logic update;
        logic upd_from_b;
        logic power_down;
    } dsc_ch_cmd_t;

    // decoded word handed to units outside this block
    typedef struct packed {
        logic [3:0]           cmd;
        logic [3:0]           addr;
        logic [DATA_BITS-1:0] data;
    } dsc_word_t;
endpackage
`default_nettype wire

// file: logic/dsc_sync.sv
// two-stage synchroniser for asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module dsc_sync
    import dsc_pkg::*;
#(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta <= RST_VAL;
            q    <= RST_VAL;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// file: logic/dsc_channel.sv
// one channel: double-buffered code and range registers
`timescale 1ns/100ps
`default_nettype none
module dsc_channel
    import dsc_pkg::*;
#(
    parameter int unsigned CODE_BITS = CODE_BITS_DEF
) (
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 clr,
    input  wire dsc_ch_cmd_t          cmd,
    input  wire logic [CODE_BITS-1:0] code_in,
    input  wire logic [3:0]           range_in,
    output var  logic [CODE_BITS-1:0] code_act,
    output var  logic [3:0]           range_act,
    output var  logic                 powered_down,
    output logic                      out_hiz,
    output logic                      out_shunt
);
    logic [CODE_BITS-1:0] code_a;
    logic [CODE_BITS-1:0] code_b;
    logic [3:0]           range_hold;
    logic [CODE_BITS-1:0] next_code_a;
    logic [CODE_BITS-1:0] next_code_b;
    logic [3:0]           next_range_hold;
    logic [CODE_BITS-1:0] next_code_act;
    logic [3:0]           next_range_act;
    logic                 next_powered_down;

    // writes touch holding registers only; updates copy both sets
    always_comb begin
        next_code_a       = code_a;
        next_code_b       = code_b;
        next_range_hold   = range_hold;
        next_code_act     = code_act;
        next_range_act    = range_act;
        next_powered_down = powered_down;
        if (clr) begin
            next_code_a       = '0;
            next_code_b       = '0;
            next_range_hold   = RANGE_RST;
            next_code_act     = '0;
            next_range_act    = RANGE_RST;
            next_powered_down = 1'b0;
        end else begin
            if (cmd.wr_code && cmd.wr_to_b) begin
                next_code_b = code_in;
            end else if (cmd.wr_code) begin
                next_code_a = code_in;
            end
            if (cmd.wr_range) begin
                next_range_hold = range_in;
            end
            if (cmd.power_down) begin
                next_powered_down = 1'b1;
            end
            // update wins over power down in the same cycle
            if (cmd.update) begin
                next_code_act     = cmd.upd_from_b ? next_code_b
                                                   : next_code_a;
                next_range_act    = next_range_hold;
                next_powered_down = 1'b0;
            end
        end
    end

    // holding and active registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            code_a       <= '0;
            code_b       <= '0;
            range_hold   <= RANGE_RST;
            code_act     <= '0;
            range_act    <= RANGE_RST;
            powered_down <= 1'b0;
        end else begin
            code_a       <= next_code_a;
            code_b       <= next_code_b;
            range_hold   <= next_range_hold;
            code_act     <= next_code_act;
            range_act    <= next_range_act;
            powered_down <= next_powered_down;
        end
    end

    // output stage mode from the active range
    always_comb begin
        out_shunt = !powered_down && range_act == RANGE_SHUNT;
        out_hiz   = powered_down || range_act == RANGE_HIZ ||
                    (range_act > RANGE_LOW_MAX &&
                     range_act != RANGE_TOP &&
                     range_act != RANGE_SHUNT);
    end
endmodule
`default_nettype wire

// file: test/dsc_top_asserts.sv
// port-level assertion checker of the serial command register bank
`timescale 1ns/100ps
`default_nettype none
module dsc_top_asserts
    import dsc_pkg::*;
#(
    parameter int unsigned NUM_CH    = 5,
    parameter int unsigned CODE_BITS = 16
) (
    input wire logic                        CLK_SYS,
    input wire logic                        NRST,
    input wire logic                        SELECT_AND_LOAD_N,
    input wire logic                        ASYNC_UPDATE_N,
    input wire logic                        ASYNC_CLEAR_N,
    input wire logic                        TOGGLE_INPUT_PIN,
    input wire logic                        SDO_OE,
    input wire logic [NUM_CH*CODE_BITS-1:0] CODE_OUT,
    input wire logic [NUM_CH*4-1:0]         RANGE_OUT,
    input wire logic [NUM_CH-1:0]           OUT_HIZ,
    input wire logic [NUM_CH-1:0]           OUT_SHUNT,
    input wire logic [NUM_CH-1:0]           POWERED_DOWN,
    input wire logic                        AUX_CMD_VALID,
    input wire dsc_word_t                   AUX_CMD
);
    logic [NUM_CH-1:0] exp_hiz;
    logic [NUM_CH-1:0] exp_shunt;

    // expected pin states from active range and power state
    always_comb begin
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < NUM_CH; i++) begin
            r = RANGE_OUT[i*4 +: 4];
            exp_shunt[i] = (r == RANGE_SHUNT) && !POWERED_DOWN[i];
            exp_hiz[i] = POWERED_DOWN[i] || !(r inside
                {[4'h1:RANGE_LOW_MAX], RANGE_SHUNT, RANGE_TOP});
        end
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!NRST);

    // serial output follows the select line
    a_sdo_off_idle: assert property (
        SELECT_AND_LOAD_N [*4] |-> !SDO_OE)
        else $error("serial output driven while deselected");
    a_sdo_on_sel: assert property (
        !SELECT_AND_LOAD_N [*5] |-> SDO_OE)
        else $error("serial output off while selected");
    a_reset_hiz: assert property (
        $rose(NRST) |-> &OUT_HIZ && CODE_OUT == '0 && RANGE_OUT == '0)
        else $error("outputs not high impedance after reset");
    // nothing moves while shifting without a trigger
    a_hold_outputs: assert property (
        (!SELECT_AND_LOAD_N && ASYNC_CLEAR_N && $stable(ASYNC_UPDATE_N)
        && $stable(TOGGLE_INPUT_PIN)) [*8]
        |=> $stable(CODE_OUT) && $stable(RANGE_OUT))
        else $error("active registers changed during shifting");
    a_update_pin: assert property (
        SELECT_AND_LOAD_N [*8] ##0 ($fell(ASYNC_UPDATE_N) && ASYNC_CLEAR_N)
        |-> ##[2:6] POWERED_DOWN == '0)
        else $error("update pin did not power up channels");
    a_hiz_map: assert property (
        $stable(RANGE_OUT) && $stable(POWERED_DOWN) |-> OUT_HIZ == exp_hiz)
        else $error("high impedance flags disagree with range");
    a_shunt_map: assert property (
        $stable(RANGE_OUT) && $stable(POWERED_DOWN)
        |-> OUT_SHUNT == exp_shunt)
        else $error("shunt flags disagree with range");
    a_clear_zero: assert property (
        !ASYNC_CLEAR_N [*6] |-> CODE_OUT == '0 && RANGE_OUT == '0)
        else $error("clear did not zero codes and ranges");
    a_aux_pulse: assert property (
        AUX_CMD_VALID |=> !AUX_CMD_VALID)
        else $error("aux strobe longer than one cycle");
    a_aux_kind: assert property (
        AUX_CMD_VALID |-> AUX_CMD.cmd inside {4'h7, 4'hb, 4'hc, 4'hd}
        && AUX_CMD.addr < 4'h5)
        else $error("aux strobe for wrong command or channel");
endmodule

bind dsc_top dsc_top_asserts #(
    .NUM_CH    (NUM_CH),
    .CODE_BITS (CODE_BITS)
) u_asserts (
    .CLK_SYS           (CLK_SYS),
    .NRST              (NRST),
    .SELECT_AND_LOAD_N (SELECT_AND_LOAD_N),
    .ASYNC_UPDATE_N    (ASYNC_UPDATE_N),
    .ASYNC_CLEAR_N     (ASYNC_CLEAR_N),
    .TOGGLE_INPUT_PIN  (TOGGLE_INPUT_PIN),
    .SDO_OE            (SDO_OE),
    .CODE_OUT          (CODE_OUT),
    .RANGE_OUT         (RANGE_OUT),
    .OUT_HIZ           (OUT_HIZ),
    .OUT_SHUNT         (OUT_SHUNT),
    .POWERED_DOWN      (POWERED_DOWN),
    .AUX_CMD_VALID     (AUX_CMD_VALID),
    .AUX_CMD           (AUX_CMD)
);
`default_nettype wire

// file: test/dsc_host_model.sv
// serial master playing the host side of the four-wire link
`timescale 1ns/100ps
`default_nettype none
module dsc_host_model #(
    parameter int unsigned HALF_NS = 40
) (
    input  wire logic        sdo,
    output var  logic        sck,
    output var  logic        sdi,
    output var  logic        cs_n,
    output var  logic [31:0] rx
);
    // idle: deselected, clock parked low
    initial begin
        sck = 1'b0;
        sdi = 1'b1;
        cs_n = 1'b1;
        rx = '0;
    end

    // data set while clock low, read back at the rising edge
    task automatic bit_out(input logic b);
        sdi = b;
        #(HALF_NS) sck = 1'b1;
        rx = {rx[30:0], sdo};
        #(HALF_NS) sck = 1'b0;
    endtask

    // frame of n bits msb first; data line released inverted after
    task automatic frame(input logic [31:0] w, input int n);
        cs_n = 1'b0;
        #(HALF_NS);
        for (int i = n - 1; i >= 0; i--) bit_out(w[i]);
        #(HALF_NS) cs_n = 1'b1;
        sdi = ~sdi;
        #(3*HALF_NS);
    endtask

    task automatic send24(input logic [23:0] w);
        frame({8'h00, w}, 24);
    endtask

    task automatic send32(input logic [31:0] w);
        frame(w, 32);
    endtask

    // select pulse without clock edges
    task automatic idle_sel(input int ns);
        cs_n = 1'b0;
        #(ns) cs_n = 1'b1;
        #(3*HALF_NS);
    endtask
endmodule
`default_nettype wire

// file: test/dsc_top_tb.sv
// self-checking bench of the serial command register bank
`timescale 1ns/100ps
`default_nettype none
module dsc_top_tb
    import dsc_pkg::*;
;
    logic        CLK_SYS = 1'b0;
    logic        NRST = 1'b0;
    logic        ASYNC_UPDATE_N = 1'b1;
    logic        ASYNC_CLEAR_N = 1'b1;
    logic        TOGGLE_INPUT_PIN = 1'b0;
    logic [4:0]  TOGGLE_SEL = '0;
    logic        WRITE_TO_B = 1'b0;
    logic [7:0]  FAULT_FLAG_BITS = '0;
    logic        SCK, SDI, SELECT_AND_LOAD_N, SDO, SDO_OE, AUX_CMD_VALID;
    logic [79:0] CODE_OUT;
    logic [19:0] RANGE_OUT;
    logic [4:0]  OUT_HIZ, OUT_SHUNT, POWERED_DOWN;
    dsc_word_t   AUX_CMD;
    logic [31:0] rx;
    logic [15:0] in_a [5] = '{default: '0};
    logic [15:0] in_b [5] = '{default: '0};
    logic [3:0]  in_r [5] = '{default: '0};
    logic [15:0] act_c [5] = '{default: '0};
    logic [3:0]  act_r [5] = '{default: '0};
    logic [4:0]  pd = '0;
    logic [23:0] prev = '0;
    logic        aux_seen = 1'b0;
    int          tests_run = 0;
    int          n_mismatch = 0;

    always #4 CLK_SYS = ~CLK_SYS;
    always @(posedge CLK_SYS) if (AUX_CMD_VALID) aux_seen <= 1'b1;

    dsc_top dut (
        .CLK_SYS(CLK_SYS), .NRST(NRST), .SCK(SCK), .SDI(SDI),
        .SELECT_AND_LOAD_N(SELECT_AND_LOAD_N),
        .ASYNC_UPDATE_N(ASYNC_UPDATE_N), .ASYNC_CLEAR_N(ASYNC_CLEAR_N),
        .TOGGLE_INPUT_PIN(TOGGLE_INPUT_PIN), .TOGGLE_SEL(TOGGLE_SEL),
        .WRITE_TO_B(WRITE_TO_B), .FAULT_FLAG_BITS(FAULT_FLAG_BITS),
        .SDO(SDO), .SDO_OE(SDO_OE), .CODE_OUT(CODE_OUT),
        .RANGE_OUT(RANGE_OUT), .OUT_HIZ(OUT_HIZ), .OUT_SHUNT(OUT_SHUNT),
        .POWERED_DOWN(POWERED_DOWN), .AUX_CMD_VALID(AUX_CMD_VALID),
        .AUX_CMD(AUX_CMD));

    dsc_host_model host (
        .sdo(SDO), .sck(SCK), .sdi(SDI), .cs_n(SELECT_AND_LOAD_N), .rx(rx));

    task automatic check(input logic [79:0] got, input logic [79:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // copy holding registers of one channel to its active pair
    function automatic void upd(input int ch, input logic from_b);
        act_c[ch] = from_b ? in_b[ch] : in_a[ch];
        act_r[ch] = in_r[ch];
        pd[ch] = 1'b0;
    endfunction

    // expected effect of one executed word
    function automatic void model(input logic [23:0] w);
        logic [3:0] c;
        logic       n;
        c = w[23:20];
        if (w[19:16] > 4'h4) return;
        for (int i = 0; i < 5; i++) begin
            n = (i == w[19:16]);
            if (n && c inside {4'h0, 4'h2, 4'h3} || c inside {4'h8, 4'ha})
                if (WRITE_TO_B) in_b[i] = w[15:0];
                else in_a[i] = w[15:0];
            if (n && c == 4'h6 || c == 4'he) in_r[i] = w[3:0];
            if (n && c == 4'h4 || c == 4'h5) pd[i] = 1'b1;
            if (n && c inside {4'h1, 4'h3} || c inside {4'h2, 4'h9, 4'ha})
                upd(i, 1'b0);
        end
    endfunction

    task automatic compare();
        for (int i = 0; i < 5; i++) begin
            check(CODE_OUT[i*16 +: 16], act_c[i]);
            check(RANGE_OUT[i*4 +: 4], act_r[i]);
        end
        check(POWERED_DOWN, pd);
    endtask

    // one frame with fresh fault flags, then echo and state checks
    task automatic send(input logic [23:0] w, input logic wide);
        logic [7:0] f;
        f = 8'($urandom);
        @(posedge CLK_SYS) #1 FAULT_FLAG_BITS = f;
        aux_seen = 1'b0;
        if (wide) host.send32({8'($urandom), w});
        else host.send24(w);
        model(w);
        repeat (4) @(posedge CLK_SYS);
        check(aux_seen, w[23:20] inside {4'h7, 4'hb, 4'hc, 4'hd}
            && w[19:16] < 4'h5);
        if (aux_seen) check(AUX_CMD, w);
        if (wide) check(rx, {f, prev});
        else check(rx[23:0], {f, prev[23:8]});
        prev = w;
        compare();
    endtask

    task automatic pulse_update();
        @(posedge CLK_SYS) #1 ASYNC_UPDATE_N = 1'b0;
        repeat (4) @(posedge CLK_SYS);
        #1 ASYNC_UPDATE_N = 1'b1;
        repeat (6) @(posedge CLK_SYS);
    endtask

    initial begin
        logic [3:0] a;
        void'($urandom(65));
        repeat (6) @(posedge CLK_SYS);
        #1 NRST = 1'b1;
        repeat (4) @(posedge CLK_SYS);
        compare();
        check(OUT_HIZ, 5'h1f);
        $display("test reset done");
        // every command code, channel fields 0 to 6 and 15
        for (int n = 0; n < 48; n++) begin
            a = (n % 8 == 7) ? 4'hf : 4'($urandom_range(0, 6));
            send({n[3:0], a, 16'($urandom)}, 1'($urandom));
        end
        $display("test commands done");
        // update pin ignored while selected, honoured when not
        send(24'h500000, 1'b0);
        fork
            host.idle_sel(400);
            #100 pulse_update();
        join
        compare();
        pulse_update();
        for (int i = 0; i < 5; i++) upd(i, 1'b0);
        compare();
        $display("test update pin done");
        // toggle pin pulls from alternate then default register
        @(posedge CLK_SYS) #1 WRITE_TO_B = 1'b1;
        send(24'h03a5c3, 1'b0);
        @(posedge CLK_SYS) #1 WRITE_TO_B = 1'b0;
        TOGGLE_SEL = 5'h08;
        @(posedge CLK_SYS) #1 TOGGLE_INPUT_PIN = 1'b1;
        repeat (8) @(posedge CLK_SYS);
        upd(3, 1'b1);
        compare();
        @(posedge CLK_SYS) #1 TOGGLE_INPUT_PIN = 1'b0;
        repeat (8) @(posedge CLK_SYS);
        upd(3, 1'b0);
        compare();
        $display("test toggle done");
        // clear zeroes active state, then reprogram everything
        @(posedge CLK_SYS) #1 ASYNC_CLEAR_N = 1'b0;
        repeat (10) @(posedge CLK_SYS);
        check(CODE_OUT, '0);
        check(RANGE_OUT, '0);
        #1 ASYNC_CLEAR_N = 1'b1;
        act_c = '{default: '0};
        act_r = '{default: '0};
        pd = '0;
        send(24'he00005, 1'b1);
        send(24'ha0beef, 1'b0);
        $display("test clear done");
        finish_test();
    end

    // hang guard, far beyond the expected run time
    initial begin
        #500000;
        n_mismatch++;
        finish_test();
    end
endmodule
`default_nettype wire
